// ===== rtl/toc_pkg.sv
package toc_pkg;

  // Byte offsets of the registers on the APB bus.
  localparam logic [7:0] TOC_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] TOC_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] TOC_OFF_MATCH_A = 8'h08;
  localparam logic [7:0] TOC_OFF_MATCH_B = 8'h0c;
  localparam logic [7:0] TOC_OFF_COUNT = 8'h10;
  localparam logic [7:0] TOC_OFF_TOP = 8'h14;
  localparam logic [7:0] TOC_OFF_STATUS = 8'h18;

  // Field positions in the first control register.
  localparam int TOC_POS_ACTION_A = 6;
  localparam int TOC_POS_ACTION_B = 4;
  localparam int TOC_POS_FORCE_A = 3;
  localparam int TOC_POS_FORCE_B = 2;
  localparam int TOC_POS_PWM = 0;

  // Field positions in the second control register.
  localparam int TOC_POS_CLK_SEL = 0;
  localparam int TOC_POS_CLEAR_ON_MATCH = 3;

  // Field positions in the status register.
  localparam int TOC_POS_FLAG_A = 0;
  localparam int TOC_POS_FLAG_B = 1;
  localparam int TOC_POS_FLAG_OVF = 2;
  localparam int TOC_POS_PIN_A = 3;
  localparam int TOC_POS_PIN_B = 4;

  // Compare action codes outside PWM operation.
  localparam logic [1:0] TOC_ACT_OFF = 2'h0;
  localparam logic [1:0] TOC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TOC_ACT_LOW = 2'h2;
  localparam logic [1:0] TOC_ACT_HIGH = 2'h3;

  // Waveform mode codes held in the PWM field.
  localparam logic [1:0] TOC_PWM_NONE = 2'h0;
  localparam logic [1:0] TOC_PWM_UPDN = 2'h1;
  localparam logic [1:0] TOC_PWM_OVF = 2'h2;

  // Clock select codes for the count enable divider.
  localparam logic [2:0] TOC_CLK_STOP = 3'h0;
  localparam logic [2:0] TOC_CLK_DIV1 = 3'h1;
  localparam logic [2:0] TOC_CLK_DIV8 = 3'h2;
  localparam logic [2:0] TOC_CLK_DIV64 = 3'h3;

  // Prescaler terminal counts, one less than the division ratio.
  localparam logic [5:0] TOC_DIV8_LAST = 6'h07;
  localparam logic [5:0] TOC_DIV64_LAST = 6'h3f;

  // Values after reset, and the two ends of the count range.
  localparam logic [15:0] TOC_RST_COUNT = 16'h0000;
  localparam logic [15:0] TOC_RST_MATCH = 16'h0000;
  localparam logic [15:0] TOC_RST_TOP = 16'hffff;
  localparam logic [15:0] TOC_ZERO = 16'h0000;
  localparam logic [15:0] TOC_FULL = 16'hffff;

  // Counting direction of the timer.
  typedef enum logic {TOC_DIR_UP, TOC_DIR_DOWN} toc_dir_e;

  // Per-channel setting handed to the output unit.
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] action;
    logic [15:0] value;
  } toc_chan_cfg_s;

  // Timer state shared by both output units.
  typedef struct packed {
    logic [15:0] top;
    logic count_down;
    logic wrap;
  } toc_timer_s;

endpackage

// ===== rtl/toc_chan.sv
// One compare output unit; it holds the pin level of a single channel.
module toc_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire toc_pkg::toc_chan_cfg_s cfg,
  input wire toc_pkg::toc_timer_s tmr,
  input wire logic match_hit,
  input wire logic force_hit,
  output logic pin,
  output logic drive
);

  // Inverted sense in PWM modes comes from the low action bit.
  logic inv;

  assign inv = cfg.action[0];

  // The timer owns the pin only for a connected action code.
  always_comb begin
    if (cfg.mode == toc_pkg::TOC_PWM_NONE) begin
      drive = (cfg.action != toc_pkg::TOC_ACT_OFF);
    end else begin
      drive = cfg.action[1];
    end
  end

  // Pin level; the action arrives already registered, so a force in the same cycle as an action write
  // still sees the old code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
    end else begin
      case (cfg.mode)
        toc_pkg::TOC_PWM_NONE: begin
          // A real or forced match performs the same action.
          if (match_hit || force_hit) begin
            case (cfg.action)
              toc_pkg::TOC_ACT_TOGGLE: pin <= ~pin;
              toc_pkg::TOC_ACT_LOW: pin <= 1'b0;
              toc_pkg::TOC_ACT_HIGH: pin <= 1'b1;
              default: pin <= pin;
            endcase
          end
        end
        toc_pkg::TOC_PWM_UPDN: begin
          // At the extremes the level is fixed at the next match.
          if (match_hit) begin
            if (cfg.value == toc_pkg::TOC_ZERO) begin
              pin <= inv;
            end else if (cfg.value == tmr.top) begin
              pin <= ~inv;
            end else begin
              pin <= tmr.count_down ? ~inv : inv;
            end
          end
        end
        toc_pkg::TOC_PWM_OVF: begin
          // Only TOP holds the level; zero still gives a short pulse.
          if (cfg.value == tmr.top) begin
            pin <= ~inv;
          end else if (match_hit) begin
            pin <= inv;
          end else if (tmr.wrap) begin
            pin <= ~inv;
          end
        end
        default: begin
          pin <= pin;
        end
      endcase
    end
  end

endmodule

// ===== rtl/toc_top.sv
// Timer with two compare output channels behind an APB slave.
module toc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic match_pin_a,
  output logic match_pin_a_oe,
  output logic match_pin_b,
  output logic match_pin_b_oe
);

  // Returns one when the byte address names a register of this block.
  function automatic logic addr_known(input logic [7:0] a);
    begin
      case (a)
        toc_pkg::TOC_OFF_CTRL_A,
        toc_pkg::TOC_OFF_CTRL_B,
        toc_pkg::TOC_OFF_MATCH_A,
        toc_pkg::TOC_OFF_MATCH_B,
        toc_pkg::TOC_OFF_COUNT,
        toc_pkg::TOC_OFF_TOP,
        toc_pkg::TOC_OFF_STATUS: addr_known = 1'b1;
        default: addr_known = 1'b0;
      endcase
    end
  endfunction

  // Control fields held for software.
  logic [1:0] action_a_r; // Channel A action code.
  logic [1:0] action_b_r; // Channel B action code.
  logic [1:0] pwm_r; // Waveform mode.
  logic [2:0] clk_sel_r; // Count enable select.
  logic clear_count_on_match_r; // Match A clears the count outside PWM.
  logic [15:0] top_r; // TOP used by both PWM modes.

  // Compare values: the buffer is what software wrote, the active copy is what the comparator uses.
  logic [15:0] buf_a_r;
  logic [15:0] buf_b_r;
  logic [15:0] act_a_r;
  logic [15:0] act_b_r;

  // Timer state.
  logic [15:0] count_r; // Present count.
  toc_pkg::toc_dir_e dir_r; // Present direction in up/down PWM.
  logic [5:0] pre_r; // Prescaler count.
  logic tick; // One-cycle count enable.

  // Status flags set by real events only.
  logic flag_a_r;
  logic flag_b_r;
  logic flag_ovf_r;

  // Bus decode.
  logic wr_en; // Write in its access phase.
  logic setup_rd; // Read in its setup phase.
  logic pwm_on; // Either PWM mode selected.
  logic force_a; // One-cycle forced match on channel A.
  logic force_b; // One-cycle forced match on channel B.

  // Timer events.
  logic hit_a; // Real match on channel A.
  logic hit_b; // Real match on channel B.
  logic at_top; // Count stands at TOP on a tick.
  logic at_ovf; // Count wraps or turns at the bottom.
  logic latch_pt; // Buffered values move to the comparator.

  // Carriers for the output units.
  toc_pkg::toc_chan_cfg_s cfg_a;
  toc_pkg::toc_chan_cfg_s cfg_b;
  toc_pkg::toc_timer_s tmr;

  // The slave never stretches a transfer, so every access phase ends in its first cycle.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !addr_known(paddr);
  assign pwm_on = (pwm_r != toc_pkg::TOC_PWM_NONE);

  // A force is a combinational strobe in the single access cycle of the write, so it meets the action
  // register before that register takes the new code; a registered strobe would act one cycle late
  // and with the new code.
  always_comb begin
    force_a = 1'b0;
    force_b = 1'b0;
    if (wr_en && (paddr == toc_pkg::TOC_OFF_CTRL_A) && !pwm_on) begin
      force_a = pwdata[toc_pkg::TOC_POS_FORCE_A];
      force_b = pwdata[toc_pkg::TOC_POS_FORCE_B];
    end
  end

  // Control register writes; the force bits are not stored anywhere.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      action_a_r <= toc_pkg::TOC_ACT_OFF;
      action_b_r <= toc_pkg::TOC_ACT_OFF;
      pwm_r <= toc_pkg::TOC_PWM_NONE;
      clk_sel_r <= toc_pkg::TOC_CLK_STOP;
      clear_count_on_match_r <= 1'b0;
      top_r <= toc_pkg::TOC_RST_TOP;
    end else if (wr_en) begin
      if (paddr == toc_pkg::TOC_OFF_CTRL_A) begin
        action_a_r <= pwdata[toc_pkg::TOC_POS_ACTION_A +: 2];
        action_b_r <= pwdata[toc_pkg::TOC_POS_ACTION_B +: 2];
        pwm_r <= pwdata[toc_pkg::TOC_POS_PWM +: 2];
      end
      if (paddr == toc_pkg::TOC_OFF_CTRL_B) begin
        clk_sel_r <= pwdata[toc_pkg::TOC_POS_CLK_SEL +: 3];
        clear_count_on_match_r <= pwdata[toc_pkg::TOC_POS_CLEAR_ON_MATCH];
      end
      if (paddr == toc_pkg::TOC_OFF_TOP) begin
        top_r <= pwdata[15:0];
      end
    end
  end

  // Software always writes the buffer, so a read returns the newest value even while the comparator
  // still works on the older one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_a_r <= toc_pkg::TOC_RST_MATCH;
      buf_b_r <= toc_pkg::TOC_RST_MATCH;
    end else if (wr_en) begin
      if (paddr == toc_pkg::TOC_OFF_MATCH_A) begin
        buf_a_r <= pwdata[15:0];
      end
      if (paddr == toc_pkg::TOC_OFF_MATCH_B) begin
        buf_b_r <= pwdata[15:0];
      end
    end
  end

  // Outside PWM the comparator follows a write at once; in PWM it waits for TOP or overflow, which
  // keeps a pulse from being cut short in mid period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_a_r <= toc_pkg::TOC_RST_MATCH;
      act_b_r <= toc_pkg::TOC_RST_MATCH;
    end else if (!pwm_on) begin
      if (wr_en && (paddr == toc_pkg::TOC_OFF_MATCH_A)) begin
        act_a_r <= pwdata[15:0];
      end
      if (wr_en && (paddr == toc_pkg::TOC_OFF_MATCH_B)) begin
        act_b_r <= pwdata[15:0];
      end
    end else if (latch_pt) begin
      act_a_r <= buf_a_r;
      act_b_r <= buf_b_r;
    end
  end

  // Prescaler; slower count rates are single-cycle enables, never derived clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 6'h00;
    end else if (clk_sel_r == toc_pkg::TOC_CLK_STOP) begin
      pre_r <= 6'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end

  // Count enable from the selected division.
  always_comb begin
    case (clk_sel_r)
      toc_pkg::TOC_CLK_DIV1: tick = 1'b1;
      toc_pkg::TOC_CLK_DIV8: tick = ((pre_r & toc_pkg::TOC_DIV8_LAST) == toc_pkg::TOC_DIV8_LAST);
      toc_pkg::TOC_CLK_DIV64: tick = (pre_r == toc_pkg::TOC_DIV64_LAST);
      default: tick = 1'b0;
    endcase
  end

  // Timer events seen on a tick.
  assign hit_a = tick && (count_r == act_a_r);
  assign hit_b = tick && (count_r == act_b_r);
  assign at_top = tick && (count_r == top_r);

  // Overflow: wrap at all ones, wrap after TOP, or turn at the bottom in up/down mode.
  always_comb begin
    case (pwm_r)
      toc_pkg::TOC_PWM_NONE: at_ovf = tick && (count_r == toc_pkg::TOC_FULL);
      toc_pkg::TOC_PWM_OVF: at_ovf = at_top;
      toc_pkg::TOC_PWM_UPDN: at_ovf = tick && (count_r == toc_pkg::TOC_ZERO) && (dir_r == toc_pkg::TOC_DIR_DOWN);
      default: at_ovf = 1'b0;
    endcase
  end

  // The buffered compare values move at TOP in up/down mode and at the wrap in overflow mode.
  always_comb begin
    case (pwm_r)
      toc_pkg::TOC_PWM_UPDN: latch_pt = at_top && (dir_r == toc_pkg::TOC_DIR_UP);
      toc_pkg::TOC_PWM_OVF: latch_pt = at_top;
      default: latch_pt = 1'b0;
    endcase
  end

  // Counter; a real match A clears it outside PWM and TOP clears it in overflow PWM; a forced match never does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= toc_pkg::TOC_RST_COUNT;
    end else if (wr_en && (paddr == toc_pkg::TOC_OFF_COUNT)) begin
      count_r <= pwdata[15:0];
    end else if (tick) begin
      case (pwm_r)
        toc_pkg::TOC_PWM_NONE: begin
          if (clear_count_on_match_r && hit_a) begin
            count_r <= toc_pkg::TOC_ZERO;
          end else begin
            count_r <= count_r + 16'h0001;
          end
        end
        toc_pkg::TOC_PWM_OVF: begin
          count_r <= at_top ? toc_pkg::TOC_ZERO : count_r + 16'h0001;
        end
        toc_pkg::TOC_PWM_UPDN: begin
          if (dir_r == toc_pkg::TOC_DIR_UP) begin
            count_r <= at_top ? count_r - 16'h0001 : count_r + 16'h0001;
          end else begin
            count_r <= (count_r == toc_pkg::TOC_ZERO) ? count_r + 16'h0001 : count_r - 16'h0001;
          end
        end
        default: begin
          count_r <= count_r;
        end
      endcase
    end
  end

  // Direction in up/down mode; other modes always count up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= toc_pkg::TOC_DIR_UP;
    end else if (pwm_r != toc_pkg::TOC_PWM_UPDN) begin
      dir_r <= toc_pkg::TOC_DIR_UP;
    end else if (tick) begin
      case (dir_r)
        toc_pkg::TOC_DIR_UP: begin
          if (count_r == top_r) begin
            dir_r <= toc_pkg::TOC_DIR_DOWN;
          end
        end
        toc_pkg::TOC_DIR_DOWN: begin
          if (count_r == toc_pkg::TOC_ZERO) begin
            dir_r <= toc_pkg::TOC_DIR_UP;
          end
        end
        default: begin
          dir_r <= toc_pkg::TOC_DIR_UP;
        end
      endcase
    end
  end

  // Sticky flags: only real timer events (match A, match B, overflow) set them, and a set in the same cycle as a clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
      flag_ovf_r <= 1'b0;
    end else begin
      if (hit_a) begin
        flag_a_r <= 1'b1;
      end else if (wr_en && (paddr == toc_pkg::TOC_OFF_STATUS) && pwdata[toc_pkg::TOC_POS_FLAG_A]) begin
        flag_a_r <= 1'b0;
      end
      if (hit_b) begin
        flag_b_r <= 1'b1;
      end else if (wr_en && (paddr == toc_pkg::TOC_OFF_STATUS) && pwdata[toc_pkg::TOC_POS_FLAG_B]) begin
        flag_b_r <= 1'b0;
      end
      if (at_ovf) begin
        flag_ovf_r <= 1'b1;
      end else if (wr_en && (paddr == toc_pkg::TOC_OFF_STATUS) && pwdata[toc_pkg::TOC_POS_FLAG_OVF]) begin
        flag_ovf_r <= 1'b0;
      end
    end
  end

  // Read data is loaded in the setup cycle, so it stands in a flip-flop for the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= 32'h00000000;
      case (paddr)
        toc_pkg::TOC_OFF_CTRL_A: begin
          // The force positions stay zero.
          prdata[toc_pkg::TOC_POS_ACTION_A +: 2] <= action_a_r;
          prdata[toc_pkg::TOC_POS_ACTION_B +: 2] <= action_b_r;
          prdata[toc_pkg::TOC_POS_PWM +: 2] <= pwm_r;
        end
        toc_pkg::TOC_OFF_CTRL_B: begin
          prdata[toc_pkg::TOC_POS_CLK_SEL +: 3] <= clk_sel_r;
          prdata[toc_pkg::TOC_POS_CLEAR_ON_MATCH] <= clear_count_on_match_r;
        end
        toc_pkg::TOC_OFF_MATCH_A: prdata[15:0] <= buf_a_r;
        toc_pkg::TOC_OFF_MATCH_B: prdata[15:0] <= buf_b_r;
        toc_pkg::TOC_OFF_COUNT: prdata[15:0] <= count_r;
        toc_pkg::TOC_OFF_TOP: prdata[15:0] <= top_r;
        toc_pkg::TOC_OFF_STATUS: begin
          prdata[toc_pkg::TOC_POS_FLAG_A] <= flag_a_r;
          prdata[toc_pkg::TOC_POS_FLAG_B] <= flag_b_r;
          prdata[toc_pkg::TOC_POS_FLAG_OVF] <= flag_ovf_r;
          prdata[toc_pkg::TOC_POS_PIN_A] <= match_pin_a;
          prdata[toc_pkg::TOC_POS_PIN_B] <= match_pin_b;
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Carriers for the two output units.
  assign cfg_a = '{mode: pwm_r, action: action_a_r, value: act_a_r};
  assign cfg_b = '{mode: pwm_r, action: action_b_r, value: act_b_r};
  assign tmr = '{top: top_r, count_down: (dir_r == toc_pkg::TOC_DIR_DOWN), wrap: at_ovf};

  // Channel A output unit.
  toc_chan u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_a),
    .tmr(tmr),
    .match_hit(hit_a),
    .force_hit(force_a),
    .pin(match_pin_a),
    .drive(match_pin_a_oe)
  );

  // Channel B output unit.
  toc_chan u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_b),
    .tmr(tmr),
    .match_hit(hit_b),
    .force_hit(force_b),
    .pin(match_pin_b),
    .drive(match_pin_b_oe)
  );

endmodule

// ===== verif/toc_top_asserts.sv
// Watches the APB side and both compare pins of the timer top.
module toc_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic match_pin_a,
  input wire logic match_pin_a_oe,
  input wire logic match_pin_b,
  input wire logic match_pin_b_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrl_r; // Shadow of the first control register.
  logic [2:0] clk_r; // Shadow of the clock select field.
  logic [15:0] val_a_r; // Last value written for channel A.
  logic wr_w; // A write completes at this edge.
  logic rd_w; // A read completes at this edge.
  logic exp_a; // Pin A level that a force would give.
  logic exp_b; // Pin B level that a force would give.
  assign wr_w = psel && penable && pwrite && pready;
  assign rd_w = psel && penable && !pwrite;
  assign exp_a = (ctrl_r[7:6] == 2'h1) ? !match_pin_a : ctrl_r[6];
  assign exp_b = (ctrl_r[5:4] == 2'h1) ? !match_pin_b : ctrl_r[4];

  // Shadows follow completed writes so the old settings are known.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 8'h00;
      clk_r <= 3'h0;
      val_a_r <= 16'h0000;
    end else if (wr_w) begin
      // Only mapped offsets change a shadow.
      if (paddr == toc_pkg::TOC_OFF_CTRL_A) ctrl_r <= pwdata[7:0];
      if (paddr == toc_pkg::TOC_OFF_CTRL_B) clk_r <= pwdata[2:0];
      if (paddr == toc_pkg::TOC_OFF_MATCH_A) val_a_r <= pwdata[15:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The timer is stopped in the force checks, so only the force acts on a pin.
  force_pin_a: assert property (wr_w && paddr == 8'h00 && pwdata[3] && ctrl_r[1:0] == 2'h0
    && ctrl_r[7:6] != 2'h0 && clk_r == 3'h0 |=> match_pin_a == $past(exp_a))
    else $error("force on channel A gave a wrong pin level");
  force_pin_b_a: assert property (wr_w && paddr == 8'h00 && pwdata[2] && ctrl_r[1:0] == 2'h0
    && ctrl_r[5:4] != 2'h0 && clk_r == 3'h0 |=> match_pin_b == $past(exp_b))
    else $error("force on channel B gave a wrong pin level");
  pwm_force_a: assert property (wr_w && paddr == 8'h00 && pwdata[3:2] != 2'h0 && pwdata[1:0] != 2'h0
    && ctrl_r[1:0] != 2'h0 && clk_r == 3'h0 |=> $stable(match_pin_a) && $stable(match_pin_b))
    else $error("force in PWM mode moved a pin");
  force_read_a: assert property (rd_w && paddr == 8'h00 |-> prdata[3:2] == 2'h0)
    else $error("force bits did not read zero");
  match_read_a: assert property (rd_w && paddr == 8'h08 |-> prdata == {16'h0000, val_a_r})
    else $error("match value A read back differs from last write");
  oe_chan_a: assert property (match_pin_a_oe == (ctrl_r[1:0] == 2'h0 ? ctrl_r[7:6] != 2'h0 : ctrl_r[7]))
    else $error("pin A enable does not follow its action");
  oe_chan_b_a: assert property (match_pin_b_oe == (ctrl_r[1:0] == 2'h0 ? ctrl_r[5:4] != 2'h0 : ctrl_r[5]))
    else $error("pin B enable does not follow its action");
  bus_resp_a: assert property (psel && penable |-> pready && (pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0)))
    else $error("bus response wrong for this address");

  // The main scenarios really happen.
  cover property (wr_w && paddr == 8'h00 && pwdata[3] && ctrl_r[7:6] == 2'h1);
  cover property (wr_w && paddr == 8'h00 && pwdata[2] && ctrl_r[1:0] != 2'h0);
  cover property (psel && penable && pslverr);
endmodule

// ===== verif/test_toc_top.sv
// Self-checking bench for the timer compare outputs.
module test_toc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pa;
  logic pa_oe;
  logic pb;
  logic pb_oe;
  logic [31:0] rd; // Data of the last read.
  logic er; // Error response of the last transfer.
  int num_errors = 0;
  int n_checks = 0;

  toc_top u_toc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_pin_a(pa), .match_pin_a_oe(pa_oe), .match_pin_b(pb), .match_pin_b_oe(pb_oe));

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    chk32({31'h0, got}, {31'h0, exp}, msg);
  endtask

  // One APB transfer; a wait that never sees pready is ended by the watchdog.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset values seen through the bus and at the pins.
  task automatic t_reset;
    bus(1'b0, toc_pkg::TOC_OFF_TOP, 32'h0);
    chk32(rd, 32'h0000ffff, "top reset");
    bus(1'b0, toc_pkg::TOC_OFF_COUNT, 32'h0);
    chk32(rd, 32'h0, "count reset");
    chk32({28'h0, pa, pa_oe, pb, pb_oe}, 32'h0, "pins reset");
  endtask

  // Each action code but OFF forced on both channels, then an action change with a force.
  task automatic t_force;
    logic e;
    e = 1'b0;
    for (int c = 3; c >= 1; c--) begin
      bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'(c * 8'h50));
      bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'(c * 8'h50 + 8'h0c));
      e = (c == 1) ? !e : c[0];
      @(negedge pclk);
      chk1(pa, e, "forced pin A");
      chk1(pb, e, "forced pin B");
    end
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000f4);
    @(negedge pclk);
    chk32({30'h0, pa, pb}, {30'h0, e, !e}, "force uses old action");
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000fc);
    @(negedge pclk);
    chk32({30'h0, pa, pb}, 32'h3, "new action on next force");
    bus(1'b0, toc_pkg::TOC_OFF_CTRL_A, 32'h0);
    chk32(rd, 32'h000000f0, "force bits read zero");
  endtask

  // A force touches neither count nor flags, even with clear on match.
  task automatic t_side;
    bus(1'b1, toc_pkg::TOC_OFF_COUNT, 32'h00000033);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_B, 32'h00000008);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000a8);
    bus(1'b0, toc_pkg::TOC_OFF_COUNT, 32'h0);
    chk32(rd, 32'h00000033, "count after force");
    bus(1'b0, toc_pkg::TOC_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00000018, "flags after force");
  endtask

  // Forces are ignored while a PWM mode is set.
  task automatic t_pwm_force;
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000a1);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000ad);
    @(negedge pclk);
    chk32({30'h0, pa, pb}, 32'h3, "pins kept in PWM");
  endtask

  // Counts pin A and pin B highs over ten cycles of a running wave.
  task automatic sample(output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (10) begin
      @(negedge pclk);
      ha += pa;
      hb += pb;
    end
  endtask

  // Waves with match A at TOP and match B at zero, in both PWM modes.
  task automatic t_wave;
    int ha;
    int hb;
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_B, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_TOP, 32'h00000004);
    // The count must start below TOP, or the wave only begins after a full 16-bit wrap.
    bus(1'b1, toc_pkg::TOC_OFF_COUNT, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_MATCH_A, 32'h00000004);
    bus(1'b1, toc_pkg::TOC_OFF_MATCH_B, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000a2);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_B, {29'h0, toc_pkg::TOC_CLK_DIV1});
    chk32({30'h0, pa_oe, pb_oe}, 32'h3, "pins claimed in PWM");
    repeat (20) @(posedge pclk);
    sample(ha, hb);
    chk32(ha, 32'h0000000a, "ovf PWM at TOP held");
    chk1(hb > 0 && hb < 10, 1'b1, "ovf PWM at zero moves");
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h000000a1);
    repeat (30) @(posedge pclk);
    sample(ha, hb);
    chk32({ha[15:0], hb[15:0]}, {16'h000a, 16'h0000}, "up/down at TOP and zero");
    bus(1'b1, toc_pkg::TOC_OFF_MATCH_A, 32'h00000002);
    bus(1'b0, toc_pkg::TOC_OFF_MATCH_A, 32'h0);
    chk32(rd, 32'h00000002, "pending value read back");
    // Once latched at TOP, a mid value makes pin A move within each period.
    repeat (20) @(posedge pclk);
    sample(ha, hb);
    chk1(ha > 0 && ha < 10, 1'b1, "latched value moves pin A");
  endtask

  // A real match A clears the count when asked, at the slowest count rate.
  task automatic t_clear;
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_B, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_A, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_COUNT, 32'h0);
    bus(1'b1, toc_pkg::TOC_OFF_MATCH_A, 32'h00000003);
    bus(1'b1, toc_pkg::TOC_OFF_STATUS, 32'h00000007);
    bus(1'b0, toc_pkg::TOC_OFF_STATUS, 32'h0);
    chk32({29'h0, rd[2:0]}, 32'h0, "flags cleared");
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_B, {28'h0, 1'b1, toc_pkg::TOC_CLK_DIV64});
    // Four ticks of the divide-by-64 enable reach the match well inside this wait.
    repeat (300) @(posedge pclk);
    bus(1'b1, toc_pkg::TOC_OFF_CTRL_B, 32'h00000008);
    bus(1'b0, toc_pkg::TOC_OFF_COUNT, 32'h0);
    chk1(rd[15:0] <= 16'h0003, 1'b1, "count cleared on match A");
    bus(1'b0, toc_pkg::TOC_OFF_STATUS, 32'h0);
    chk1(rd[0], 1'b1, "real match A sets its flag");
  endtask

  // An unmapped offset answers with an error and reads zero.
  task automatic t_unmapped;
    bus(1'b1, 8'h1c, 32'h12345678);
    chk1(er, 1'b1, "unmapped write error");
    bus(1'b0, 8'h1c, 32'h0);
    chk32({er, rd[30:0]}, 32'h80000000, "unmapped read");
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_force;
    t_side;
    t_pwm_force;
    t_wave;
    t_clear;
    t_unmapped;
    close_out;
  end

  // The run needs about 550 cycles; far beyond that is a hang.
  initial begin
    #200us;
    num_errors++;
    close_out;
  end
endmodule

bind toc_top toc_top_asserts u_toc_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .match_pin_a(match_pin_a), .match_pin_a_oe(match_pin_a_oe),
  .match_pin_b(match_pin_b), .match_pin_b_oe(match_pin_b_oe));
